// ---- bench/slc_motor_model.sv ----
// Behavioural motor and load on the inverter output
`timescale 1ns/1ps
`default_nettype none
module slc_motor_model
    import slc_pkg::*;
(
    input wire logic clk,
    input wire logic preset,
    input wire logic [15:0] preset_freq,
    input wire logic [15:0] load_cur,
    input wire logic [15:0] load_trq,
    input wire slc_phase_t phase,
    input wire slc_ramp_t ramp,
    input wire logic shutoff,
    output slc_meas_t meas
);
    logic [15:0] freq_q;
    // A coasting motor draws nothing once the stage is off
    assign meas = shutoff ? {16'h0000, 16'h0000, freq_q, phase}
                          : {load_cur, load_trq, freq_q, phase};
    // One count per clock so a stall visibly drags speed
    always_ff @(posedge clk) begin
        if (preset) begin
            freq_q <= preset_freq;
        end else if (ramp.dec && freq_q != 16'h0000) begin
            freq_q <= freq_q - 16'h0001;
        end else if (ramp.inc && freq_q != 16'hffff) begin
            freq_q <= freq_q + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ---- bench/slc_stall_guard_tb_top.sv ----
// Testbench for the stall-prevention supervisor
`timescale 1ns/1ps
`default_nettype none
module slc_stall_guard_tb_top;
    import slc_pkg::*;
    localparam int TK = 20;
    localparam logic [31:0] HOLD = 32'h4;
    localparam logic [31:0] DEC = 32'h2;
    localparam logic [31:0] INC = 32'h1;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic sfs, regen, ovs, shutoff, sao, trip, preset;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] pf, cur, trq;
    slc_phase_t ph;
    slc_meas_t meas;
    slc_ramp_t ramp;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    logic [7:0] offs [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
                              8'h18, 8'h1c, 8'h20, 8'h24, 8'h28};
    logic [15:0] rstv [11] = '{16'h05dc, 16'h270f, 16'h270f, 16'h1388, 16'h0000,
                               16'h0000, 16'h0000, 16'h0003, 16'h0000, 16'h07d0, 16'h9c40};
    slc_stall_guard #(.TICK_CYCLES(TK)) uut (.CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .MEAS(meas), .SECOND_FUNCTION_SELECT(sfs),
        .REGEN_AVOID_ACTIVE(regen), .OVERVOLTAGE_STALL(ovs), .RAMP_CMD(ramp),
        .OUTPUT_SHUTOFF(shutoff), .STALL_ACTIVE_OUTPUT(sao), .STALL_TRIP_FAULT(trip));
    slc_motor_model motor (.clk(clk), .preset(preset), .preset_freq(pf), .load_cur(cur),
        .load_trq(trq), .phase(ph), .ramp(ramp), .shutoff(shutoff), .meas(meas));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic tally_and_finish();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 95000) begin
            n_mismatch++;
            $display("MISMATCH %0t run did not complete", $time);
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Bus transfer; error response compared against e
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Ends once pready is high; the bench timeout catches a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        chk({31'h0, pslverr}, {31'h0, e});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ld(input logic [15:0] c, input logic [15:0] t, input slc_phase_t p);
        @(posedge clk);
        cur <= c;
        trq <= t;
        ph <= p;
    endtask
    task automatic pre(input logic [15:0] f);
        @(posedge clk);
        pf <= f;
        preset <= 1'b1;
        @(posedge clk);
        preset <= 1'b0;
    endtask
    // Whole control ticks, then look off the edge
    task automatic tk(input int n);
        repeat (n * TK) @(posedge clk);
        #2;
    endtask
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        {sfs, regen, ovs} = 3'h0;
        preset = 1'b1;
        pf = 16'h0bb8;
        cur = 16'h01f4;
        trq = 16'h0000;
        ph = SLC_PH_CONST;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        preset <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            acc(1'b0, offs[i], 32'h0, 1'b0);
            chk(rd, {16'h0000, rstv[i]});
        end
        acc(1'b0, 8'h40, 32'h0, 1'b1);
        chk(rd, 32'h0);
        // Idle status: stall state off, every flag low
        acc(1'b0, 8'h2c, 32'h0, 1'b0);
        chk(rd, 32'h20);
        acc(1'b1, 8'h20, 32'h1, 1'b0);
        acc(1'b1, 8'h00, 32'h100, 1'b1);
        acc(1'b0, 8'h00, 32'h0, 1'b0);
        chk(rd, 32'h5dc);
        acc(1'b1, 8'h20, 32'h0, 1'b0);
        pre(16'h9858);
        ld(16'h0578, 16'h0, SLC_PH_CONST);
        tk(3);
        chk({29'h0, ramp}, 32'h0);
        // Half factor above the start frequency brings the level near 75 %
        acc(1'b1, 8'h04, 32'h1f4, 1'b0);
        tk(3);
        chk({29'h0, ramp}, DEC);
        pre(16'h0bb8);
        tk(3);
        chk({29'h0, ramp}, 32'h0);
        acc(1'b1, 8'h04, 32'h270f, 1'b0);
        ld(16'h01f4, 16'h0, SLC_PH_CONST);
        tk(110);
        pre(16'h0bb8);
        ld(16'h0640, 16'h0, SLC_PH_CONST);
        tk(3);
        chk({29'h0, ramp}, DEC);
        chk({31'h0, sao}, 32'h1);
        ld(16'h01f4, 16'h0, SLC_PH_CONST);
        tk(50);
        chk({31'h0, sao}, 32'h1);
        tk(60);
        chk({31'h0, sao}, 32'h0);
        ld(16'h0640, 16'h0, SLC_PH_ACCEL);
        tk(3);
        chk({29'h0, ramp}, HOLD);
        ld(16'h0640, 16'h0, SLC_PH_DECEL);
        tk(1);
        chk({29'h0, ramp}, HOLD);
        ld(16'h01f4, 16'h0, SLC_PH_CONST);
        tk(110);
        acc(1'b1, 8'h10, 32'h2, 1'b0);
        ld(16'h0640, 16'h0, SLC_PH_ACCEL);
        tk(3);
        chk({29'h0, ramp}, 32'h0);
        // Two ticks: the new code needs a tick, then the ramp a clock
        acc(1'b1, 8'h10, 32'h64, 1'b0);
        tk(2);
        chk({29'h0, ramp}, HOLD);
        acc(1'b1, 8'h10, 32'h65, 1'b0);
        ld(16'h0834, 16'h0, SLC_PH_CONST);
        tk(1);
        chk({31'h0, shutoff}, 32'h0);
        // Cut current reads zero, so the fast flag toggles: look one clock in
        acc(1'b1, 8'h10, 32'h0, 1'b0);
        @(posedge clk);
        #2;
        chk({31'h0, shutoff}, 32'h1);
        ld(16'h01f4, 16'h0, SLC_PH_CONST);
        tk(110);
        acc(1'b1, 8'h00, 32'h0, 1'b0);
        ld(16'h0640, 16'h0, SLC_PH_CONST);
        tk(3);
        chk({29'h0, ramp}, 32'h0);
        chk({31'h0, sao}, 32'h0);
        ld(16'h01f4, 16'h0, SLC_PH_CONST);
        acc(1'b1, 8'h00, 32'h5dc, 1'b0);
        acc(1'b1, 8'h08, 32'h320, 1'b0);
        ld(16'h03e8, 16'h0, SLC_PH_CONST);
        tk(3);
        chk({29'h0, ramp}, 32'h0);
        @(posedge clk);
        sfs <= 1'b1;
        tk(3);
        chk({29'h0, ramp}, DEC);
        @(posedge clk);
        sfs <= 1'b0;
        ld(16'h01f4, 16'h0, SLC_PH_CONST);
        tk(110);
        acc(1'b1, 8'h18, 32'h1, 1'b0);
        ld(16'h0640, 16'h01f4, SLC_PH_CONST);
        tk(3);
        chk({29'h0, ramp}, 32'h0);
        ld(16'h01f4, 16'h0640, SLC_PH_CONST);
        tk(3);
        chk({29'h0, ramp}, DEC);
        pre(16'h0190);
        ld(16'h01f4, 16'h0640, SLC_PH_DECEL);
        tk(3);
        chk({29'h0, ramp}, 32'h0);
        pre(16'h0bb8);
        tk(3);
        chk({29'h0, ramp}, INC);
        ld(16'h01f4, 16'h0, SLC_PH_CONST);
        acc(1'b1, 8'h18, 32'h0, 1'b0);
        tk(110);
        acc(1'b1, 8'h1c, 32'h67, 1'b0);
        tk(1);
        chk({31'h0, sao}, 32'h1);
        acc(1'b1, 8'h1c, 32'h3, 1'b0);
        tk(1);
        chk({31'h0, sao}, 32'h0);
        acc(1'b1, 8'h14, 32'h1, 1'b0);
        @(posedge clk);
        regen <= 1'b1;
        tk(50);
        chk({31'h0, sao}, 32'h0);
        tk(60);
        chk({31'h0, sao}, 32'h1);
        @(posedge clk);
        regen <= 1'b0;
        tk(110);
        chk({31'h0, sao}, 32'h0);
        acc(1'b1, 8'h14, 32'h270f, 1'b0);
        @(posedge clk);
        ovs <= 1'b1;
        tk(5);
        chk({31'h0, sao}, 32'h0);
        @(posedge clk);
        ovs <= 1'b0;
        tk(110);
        acc(1'b1, 8'h14, 32'h0, 1'b0);
        pre(16'h0064);
        ld(16'h0640, 16'h0, SLC_PH_CONST);
        tk(2990);
        chk({31'h0, trip}, 32'h0);
        tk(20);
        chk({30'h0, trip, shutoff}, 32'h3);
        ld(16'h01f4, 16'h0, SLC_PH_CONST);
        acc(1'b1, 8'h30, 32'h1, 1'b0);
        tk(1);
        chk({31'h0, trip}, 32'h0);
        // Codes 16 to 31 stop with a fault once the stall output is on
        acc(1'b1, 8'h10, 32'h10, 1'b0);
        ld(16'h0640, 16'h0, SLC_PH_CONST);
        tk(4);
        chk({31'h0, trip}, 32'h1);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ---- core/slc_pkg.sv ----
// Package of constants, types and timing for the stall-prevention supervisor
package slc_pkg;
    // ------------------------------------------------------------
    // Register map, byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SLC_OFF_LEVEL = 8'h00;
    localparam logic [7:0] SLC_OFF_HS_FACTOR = 8'h04;
    localparam logic [7:0] SLC_OFF_LEVEL2 = 8'h08;
    localparam logic [7:0] SLC_OFF_RED_FREQ = 8'h0c;
    localparam logic [7:0] SLC_OFF_OP_SEL = 8'h10;
    localparam logic [7:0] SLC_OFF_OUT_TIMER = 8'h14;
    localparam logic [7:0] SLC_OFF_LIM_SW = 8'h18;
    localparam logic [7:0] SLC_OFF_TERM_FUNC = 8'h1c;
    localparam logic [7:0] SLC_OFF_USER_GRP = 8'h20;
    localparam logic [7:0] SLC_OFF_FAST_LIMIT = 8'h24;
    localparam logic [7:0] SLC_OFF_MAX_FREQ = 8'h28;
    localparam logic [7:0] SLC_OFF_STATUS = 8'h2c;
    localparam logic [7:0] SLC_OFF_CTRL = 8'h30;
    // ------------------------------------------------------------
    // Settings: levels in 0.1 %, frequency in 0.01 Hz, timer in 0.1 s
    // ------------------------------------------------------------
    localparam logic [15:0] SLC_RESERVED = 16'h270f;
    localparam logic [15:0] SLC_LEVEL_RST = 16'h05dc;
    localparam logic [15:0] SLC_RED_FREQ_RST = 16'h1388;
    localparam logic [15:0] SLC_FAST_LIMIT_RST = 16'h07d0;
    localparam logic [15:0] SLC_MAX_FREQ_RST = 16'h9c40;
    localparam logic [15:0] SLC_ONE_HZ = 16'h0064;
    localparam logic [15:0] SLC_FIVE_HZ = 16'h01f4;
    localparam logic [15:0] SLC_TERM_POS = 16'h0003;
    localparam logic [15:0] SLC_TERM_NEG = 16'h0067;
    localparam logic [15:0] SLC_OP_ALT0 = 16'h0064;
    localparam logic [15:0] SLC_OP_ALT1 = 16'h0065;
    localparam logic [15:0] SLC_OP_MAX = 16'h001f;
    localparam int SLC_CTRL_CLR_TRIP = 0;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SLC_CLK_PERIOD_NS = 20;
    localparam int SLC_TICK_PERIOD_NS = 1000000;
    localparam int SLC_TICK_CYCLES = SLC_TICK_PERIOD_NS / SLC_CLK_PERIOD_NS;
    localparam int SLC_OL_MIN_MS = 100;
    localparam int SLC_TRIP_HOLD_MS = 3000;
    localparam int SLC_TIMER_UNIT_MS = 100;
    localparam logic [15:0] SLC_OL_MIN_TICKS =
        16'((SLC_OL_MIN_MS * 1000000 + SLC_TICK_PERIOD_NS - 1) / SLC_TICK_PERIOD_NS);
    // Wide product: hold time in ns overflows a 32-bit int
    localparam logic [15:0] SLC_TRIP_TICKS =
        16'((longint'(SLC_TRIP_HOLD_MS) * 1000000 + SLC_TICK_PERIOD_NS - 1) / SLC_TICK_PERIOD_NS);
    localparam logic [7:0] SLC_TIMER_UNIT_TICKS =
        8'((SLC_TIMER_UNIT_MS * 1000000) / SLC_TICK_PERIOD_NS);
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SLC_PH_ACCEL = 3'b001,
        SLC_PH_CONST = 3'b010,
        SLC_PH_DECEL = 3'b100
    } slc_phase_t;
    typedef enum logic [2:0] {
        SLC_OL_OFF = 3'b001,
        SLC_OL_WAIT = 3'b010,
        SLC_OL_ON = 3'b100
    } slc_ol_state_t;
    typedef struct packed {
        logic [15:0] out_current;
        logic [15:0] torque_current;
        logic [15:0] out_freq;
        slc_phase_t phase;
    } slc_meas_t;
    typedef struct packed {
        logic hold;
        logic dec;
        logic inc;
    } slc_ramp_t;
endpackage

// ---- core/slc_stall_guard.sv ----
// Stall-prevention supervisor with APB settings and stall-active output
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module slc_stall_guard
    import slc_pkg::*;
#(
    parameter int TICK_CYCLES = SLC_TICK_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire slc_meas_t MEAS,
    input wire logic SECOND_FUNCTION_SELECT,
    input wire logic REGEN_AVOID_ACTIVE,
    input wire logic OVERVOLTAGE_STALL,
    output slc_ramp_t RAMP_CMD,
    output logic OUTPUT_SHUTOFF,
    output logic STALL_ACTIVE_OUTPUT,
    output logic STALL_TRIP_FAULT
);
    function automatic logic [15:0] scale_permille(input logic [15:0] v, input logic [15:0] f);
        logic [47:0] p;
        p = 48'(v) * 48'(f) * 48'd1049;
        return p[35:20];
    endfunction

    // ------------------------------------------------------------
    // Control tick
    // ------------------------------------------------------------
    logic tick;
    slc_tick_div #(.DIV(TICK_CYCLES)) u_div (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // APB settings
    // ------------------------------------------------------------
    logic [15:0] level_q, hs_factor_q, level2_q, red_freq_q, op_sel_q, timer_q;
    logic [15:0] term_q, ugrp_q, fast_limit_q, max_freq_q;
    logic lim_sw_q;
    logic [31:0] prdata_q;
    logic [31:0] status;
    logic [31:0] rd_mux;
    logic acc, wr, is_setting, is_mapped, wr_locked, wr_ok, clr_trip;
    assign acc = PSEL && PENABLE;
    assign wr = acc && PWRITE;
    assign is_setting = (PADDR <= SLC_OFF_TERM_FUNC) && (PADDR[1:0] == 2'b00);
    assign is_mapped = (PADDR <= SLC_OFF_CTRL) && (PADDR[1:0] == 2'b00);
    assign wr_locked = is_setting && (ugrp_q != 16'h0000);
    assign wr_ok = wr && is_mapped && !wr_locked && (PADDR != SLC_OFF_STATUS);
    assign clr_trip = wr_ok && (PADDR == SLC_OFF_CTRL) && PWDATA[SLC_CTRL_CLR_TRIP];
    assign PREADY = 1'b1;
    assign PSLVERR = acc && (!is_mapped || (PWRITE && wr_locked));
    assign PRDATA = prdata_q;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            level_q <= SLC_LEVEL_RST;
            hs_factor_q <= SLC_RESERVED;
            level2_q <= SLC_RESERVED;
            red_freq_q <= SLC_RED_FREQ_RST;
            op_sel_q <= 16'h0000;
            timer_q <= 16'h0000;
            lim_sw_q <= 1'b0;
            term_q <= SLC_TERM_POS;
            ugrp_q <= 16'h0000;
            fast_limit_q <= SLC_FAST_LIMIT_RST;
            max_freq_q <= SLC_MAX_FREQ_RST;
        end else if (wr_ok) begin
            case (PADDR)
                SLC_OFF_LEVEL: level_q <= PWDATA[15:0];
                SLC_OFF_HS_FACTOR: hs_factor_q <= PWDATA[15:0];
                SLC_OFF_LEVEL2: level2_q <= PWDATA[15:0];
                SLC_OFF_RED_FREQ: red_freq_q <= PWDATA[15:0];
                SLC_OFF_OP_SEL: op_sel_q <= PWDATA[15:0];
                SLC_OFF_OUT_TIMER: timer_q <= PWDATA[15:0];
                SLC_OFF_LIM_SW: lim_sw_q <= PWDATA[0];
                SLC_OFF_TERM_FUNC: term_q <= PWDATA[15:0];
                SLC_OFF_USER_GRP: ugrp_q <= PWDATA[15:0];
                SLC_OFF_FAST_LIMIT: fast_limit_q <= PWDATA[15:0];
                SLC_OFF_MAX_FREQ: max_freq_q <= PWDATA[15:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        case (PADDR)
            SLC_OFF_LEVEL: rd_mux = {16'h0000, level_q};
            SLC_OFF_HS_FACTOR: rd_mux = {16'h0000, hs_factor_q};
            SLC_OFF_LEVEL2: rd_mux = {16'h0000, level2_q};
            SLC_OFF_RED_FREQ: rd_mux = {16'h0000, red_freq_q};
            SLC_OFF_OP_SEL: rd_mux = {16'h0000, op_sel_q};
            SLC_OFF_OUT_TIMER: rd_mux = {16'h0000, timer_q};
            SLC_OFF_LIM_SW: rd_mux = {31'h00000000, lim_sw_q};
            SLC_OFF_TERM_FUNC: rd_mux = {16'h0000, term_q};
            SLC_OFF_USER_GRP: rd_mux = {16'h0000, ugrp_q};
            SLC_OFF_FAST_LIMIT: rd_mux = {16'h0000, fast_limit_q};
            SLC_OFF_MAX_FREQ: rd_mux = {16'h0000, max_freq_q};
            SLC_OFF_STATUS: rd_mux = status;
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Read data is captured in the setup cycle, valid through the access
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            prdata_q <= 32'h00000000;
        end else if (PSEL && !PENABLE) begin
            prdata_q <= PWRITE ? 32'h00000000 : rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Active level and comparison
    // ------------------------------------------------------------
    logic [4:0] op_code;
    logic fast_en, phase_en, tq_off, hs_active;
    logic [15:0] base_level, act_level, compared;
    logic over_d, over_q;
    // Codes 100/101 map onto 0/1; unknown codes behave as 0
    assign op_code = (op_sel_q == SLC_OP_ALT1) ? 5'h01 :
                     (op_sel_q <= SLC_OP_MAX) ? op_sel_q[4:0] : 5'h00;
    assign fast_en = !op_code[0];
    assign phase_en = (MEAS.phase == SLC_PH_ACCEL) ? !op_code[1] :
                      (MEAS.phase == SLC_PH_CONST) ? !op_code[2] : !op_code[3];
    assign base_level = (SECOND_FUNCTION_SELECT && level2_q != SLC_RESERVED) ?
                        level2_q : level_q;
    // Reserved factor leaves the level flat over the whole range
    assign hs_active = (hs_factor_q != SLC_RESERVED) && (MEAS.out_freq > red_freq_q);
    assign act_level = hs_active ? scale_permille(base_level, hs_factor_q) : base_level;
    assign compared = lim_sw_q ? MEAS.torque_current : MEAS.out_current;
    assign tq_off = lim_sw_q && (MEAS.phase == SLC_PH_DECEL) && (MEAS.out_freq <= SLC_FIVE_HZ);
    assign over_d = (act_level != 16'h0000) && (compared > act_level) && phase_en && !tq_off;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            over_q <= 1'b0;
        end else if (tick) begin
            over_q <= over_d;
        end
    end

    // ------------------------------------------------------------
    // Ramp steering and fast shut-off
    // ------------------------------------------------------------
    slc_ramp_t ramp_d, ramp_q;
    logic fast_off_q;
    always_comb begin
        ramp_d = '0;
        if (over_q) begin
            case (MEAS.phase)
                SLC_PH_ACCEL: ramp_d.hold = 1'b1;
                SLC_PH_CONST: ramp_d.dec = 1'b1;
                SLC_PH_DECEL: begin
                    if (lim_sw_q && MEAS.out_freq < max_freq_q) begin
                        ramp_d.inc = 1'b1;
                    end else begin
                        ramp_d.hold = 1'b1;
                    end
                end
                default: ramp_d = '0;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ramp_q <= '0;
            fast_off_q <= 1'b0;
        end else begin
            ramp_q <= ramp_d;
            fast_off_q <= fast_en && (MEAS.out_current > fast_limit_q);
        end
    end
    assign RAMP_CMD = ramp_q;

    // ------------------------------------------------------------
    // Stall-active output timing
    // ------------------------------------------------------------
    slc_ol_state_t ol_st_q, ol_st_d;
    logic [15:0] ol_cnt_q, ol_cnt_d;
    logic [23:0] delay_ticks;
    logic [23:0] wait_cnt_q;
    logic evt, ol_q, pin_q;
    assign evt = over_q || REGEN_AVOID_ACTIVE || OVERVOLTAGE_STALL;
    assign delay_ticks = 24'(timer_q) * 24'(SLC_TIMER_UNIT_TICKS);
    assign ol_q = (ol_st_q == SLC_OL_ON);

    always_comb begin
        ol_st_d = ol_st_q;
        ol_cnt_d = ol_cnt_q;
        case (ol_st_q)
            SLC_OL_OFF: begin
                ol_cnt_d = 16'h0000;
                if (evt && timer_q != SLC_RESERVED) begin
                    ol_st_d = (timer_q == 16'h0000) ? SLC_OL_ON : SLC_OL_WAIT;
                end
            end
            SLC_OL_WAIT: begin
                if (!evt || timer_q == SLC_RESERVED) begin
                    ol_st_d = SLC_OL_OFF;
                end else if (wait_cnt_q + 24'h000001 >= delay_ticks) begin
                    ol_st_d = SLC_OL_ON;
                end
            end
            SLC_OL_ON: begin
                if (ol_cnt_q < SLC_OL_MIN_TICKS) begin
                    ol_cnt_d = ol_cnt_q + 16'h0001;
                end
                if (!evt && ol_cnt_q >= SLC_OL_MIN_TICKS) begin
                    ol_st_d = SLC_OL_OFF;
                end
            end
            default: ol_st_d = SLC_OL_OFF;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ol_st_q <= SLC_OL_OFF;
            ol_cnt_q <= 16'h0000;
            wait_cnt_q <= 24'h000000;
        end else if (tick) begin
            ol_st_q <= ol_st_d;
            ol_cnt_q <= ol_cnt_d;
            wait_cnt_q <= (ol_st_q == SLC_OL_WAIT) ? wait_cnt_q + 24'h000001 : 24'h000000;
        end
    end

    // Other terminal functions belong elsewhere; this pin idles low then
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= (term_q == SLC_TERM_POS) ? ol_q :
                     (term_q == SLC_TERM_NEG) ? !ol_q : 1'b0;
        end
    end
    assign STALL_ACTIVE_OUTPUT = pin_q;

    // ------------------------------------------------------------
    // Stall trip: low-frequency stall, or codes 16 to 31 with the stall output on
    // ------------------------------------------------------------
    logic [15:0] trip_cnt_q;
    logic trip_q, trip_set, low_stall;
    assign low_stall = over_q && (MEAS.out_freq <= SLC_ONE_HZ);
    assign trip_set = tick && ((low_stall && trip_cnt_q == SLC_TRIP_TICKS - 16'h0001) ||
                               (op_code[4] && ol_q));
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            trip_cnt_q <= 16'h0000;
            trip_q <= 1'b0;
        end else begin
            if (tick) begin
                trip_cnt_q <= low_stall ? trip_cnt_q + 16'h0001 : 16'h0000;
            end
            // Set wins over a simultaneous clear
            trip_q <= trip_set || (trip_q && !clr_trip);
        end
    end
    assign STALL_TRIP_FAULT = trip_q;
    assign OUTPUT_SHUTOFF = fast_off_q || trip_q;
    assign status = {24'h000000, ol_st_q, over_q, fast_off_q, ol_q, trip_q, pin_q};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    ol_min_hold_a: assert property ($fell(ol_q) |-> $past(ol_cnt_q) >= SLC_OL_MIN_TICKS)
        else $error("stall output dropped before minimum hold");
    fast_cut_a: assert property (fast_en && MEAS.out_current > fast_limit_q |=> OUTPUT_SHUTOFF)
        else $error("fast limit did not cut output");
    trip_timing_a: assert property (tick && low_stall && trip_cnt_q == SLC_TRIP_TICKS - 16'h0001
        |=> STALL_TRIP_FAULT && OUTPUT_SHUTOFF)
        else $error("low frequency stall did not trip");
    ramp_phase_a: assert property (over_q && MEAS.phase == SLC_PH_CONST |=> RAMP_CMD.dec)
        else $error("constant speed stall did not decelerate");
    accel_hold_a: assert property (over_q && MEAS.phase == SLC_PH_ACCEL
        |=> RAMP_CMD.hold && !RAMP_CMD.inc)
        else $error("acceleration not held during stall");
    timer_off_a: assert property ($rose(ol_q) |-> $past(timer_q) != SLC_RESERVED)
        else $error("stall output raised while suppressed");
    pin_polarity_a: assert property (term_q == SLC_TERM_NEG && $stable(term_q)
        |=> STALL_ACTIVE_OUTPUT == !$past(ol_q))
        else $error("inverted stall terminal wrong");
    zero_level_a: assert property (tick && act_level == 16'h0000 |=> !over_q)
        else $error("zero level did not disable stall");
    torque_low_a: assert property (tick && tq_off |=> !over_q)
        else $error("torque limit active at low decel speed");
    raise_cap_a: assert property (RAMP_CMD.inc |-> $past(MEAS.out_freq) < $past(max_freq_q))
        else $error("frequency raised past maximum");
    write_lock_a: assert property (wr && is_setting && ugrp_q != 16'h0000
        |=> $stable(level_q) && $stable(timer_q))
        else $error("locked setting was written");

    stall_on_c: cover property ($rose(ol_q));
    trip_c: cover property ($rose(STALL_TRIP_FAULT));
    delayed_c: cover property (ol_st_q == SLC_OL_WAIT ##1 ol_st_q == SLC_OL_ON);
    regen_raise_c: cover property (RAMP_CMD.inc);
endmodule
`default_nettype wire

// ---- core/slc_tick_div.sv ----
// Control-cycle enable divider for the stall-prevention supervisor
`timescale 1ns/1ps
`default_nettype none
module slc_tick_div #(
    parameter int DIV = 50000
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);
    if (DIV < 2 || DIV > 65536) begin : g_div_check
        $error("slc_tick_div: DIV out of range");
    end
    logic [15:0] cnt_q;
    logic last;
    assign last = (cnt_q == 16'(DIV - 1));
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= last ? 16'h0000 : cnt_q + 16'h0001;
        end
    end
    assign tick = last;
endmodule
`default_nettype wire
